// ===== hdl/lbm_pkg.sv
// Package for the loopback test multiplexer.
// Assumes one 100 MHz clock and an active-low asynchronous reset.
package lbm_pkg;
  // Test mode control register
  localparam logic [7:0] LBM_TEST_MODE_CONTROL_ADDR = 8'h0d;
  localparam logic [7:0] LBM_TEST_MODE_CONTROL_RESET = 8'h00;
  // Field positions in the test mode control register
  localparam int LBM_BIT_ANALOG_LOOP = 7;
  localparam int LBM_BIT_DIGITAL_LOOP = 6;
  localparam int LBM_BIT_RX_TRISTATE = 5;
  // Widths of the data paths
  localparam int LBM_ADC_W = 12;
  localparam int LBM_PORT_W = 6;
  localparam logic [LBM_PORT_W-1:0] LBM_PORT_ZERO = 6'h00;
  localparam logic [LBM_ADC_W-1:0] LBM_ADC_ZERO = 12'h000;
  // Interface mode strap values
  localparam logic LBM_MODE_HALF = 1'b0;
  localparam logic LBM_MODE_FULL = 1'b1;
endpackage : lbm_pkg

// ===== hdl/lbm_skid.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes source and sink share the clock; output data is registered.
`timescale 1ns/1ps
module lbm_skid
  import lbm_pkg::*;
#(
  parameter int W = 12 // Word width
)
(
  input wire logic clk, // Clock
  input wire logic rst_b, // Async reset, active low
  input wire logic in_valid, // Source offers a word
  output logic in_ready, // Buffer can take a word
  input wire logic [W-1:0] in_data, // Source word
  output logic out_valid, // Head word present
  input wire logic out_ready, // Sink takes head word
  output logic [W-1:0] out_data // Head word
);
  logic [W-1:0] mem [0:1]; // Storage for the two entries
  logic [W-1:0] next_mem0; // Next entry 0
  logic [W-1:0] next_mem1; // Next entry 1
  logic [1:0] count; // Entries held
  logic [1:0] next_count; // Next entry count
  logic push; // Word accepted
  logic pop; // Word delivered

  // Entry 0 is always the head, so the output is a plain register read
  always_comb
  begin
    push = in_valid && (count != 2'h2);
    pop = out_valid && out_ready;
    next_mem0 = mem[0];
    next_mem1 = mem[1];
    next_count = count;
    if (pop)
    begin
      // Shift forward; a push here only happens with one entry held, so the new word becomes the head
      next_mem0 = mem[1];
      if (push && count == 2'h1)
        next_mem0 = in_data;
      else if (push)
        next_mem1 = in_data;
    end
    else if (push)
    begin
      // Fill the first free slot
      if (count == 2'h0)
        next_mem0 = in_data;
      else
        next_mem1 = in_data;
    end
    next_count = 2'(count + {1'b0, push} - {1'b0, pop});
  end

  // State registers only
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem[0] <= '0;
      mem[1] <= '0;
      count <= 2'h0;
    end
    else
    begin
      mem[0] <= next_mem0;
      mem[1] <= next_mem1;
      count <= next_count;
    end
  end

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[0];
endmodule : lbm_skid

// ===== hdl/lbm_loopback_test_mux.sv
// Test-mode routing between receive converter, transmit path and ports.
// Assumes a register write port from the serial port logic, one clock.
// Function
// - Analog loopback sends ADC samples to transmit
// - Analog loopback works in either interface mode
// - Digital loopback returns transmit word to receive, in full duplex mode only
// - Tristate bit floats the receive data port
`timescale 1ns/1ps
module lbm_loopback_test_mux
  import lbm_pkg::*;
(
  input wire logic CLK, // 100 MHz clock
  input wire logic RST_B, // Async reset, active low
  input wire logic REG_WE, // Register write strobe
  input wire logic [7:0] REG_ADDR, // Register address
  input wire logic [7:0] REG_WDATA, // Register write data
  output logic [7:0] REG_RDATA, // Register read data
  input wire logic MODE_PIN, // Interface mode strap, high = full duplex
  input wire logic [LBM_ADC_W-1:0] ADC_DATA, // Receive converter samples
  input wire logic ADC_VALID, // Sample valid
  output logic ADC_READY, // Receive path can take a sample
  input wire logic [LBM_ADC_W-1:0] TXP_DATA, // Host transmit word
  input wire logic TXP_VALID, // Host transmit valid
  output logic [LBM_ADC_W-1:0] INTERP_DATA, // Into interpolation filters
  output logic INTERP_VALID, // Interpolator word valid
  input wire logic INTERP_READY, // Interpolator takes word
  input wire logic [LBM_PORT_W-1:0] TX_PORT, // Transmit data pins
  output logic [LBM_PORT_W-1:0] RX_PORT_O, // Receive data pins out
  output logic [LBM_PORT_W-1:0] RX_PORT_OE, // Receive pin drive enables
  input wire logic [LBM_PORT_W-1:0] RXP_DATA, // Normal receive port word
  output logic ANALOG_LOOP_ACTIVE // Analog loopback in force
);
  logic [7:0] test_ctrl; // Test mode control register
  logic [7:0] next_test_ctrl; // Next control value
  logic [7:0] rdata; // Read data register
  logic [7:0] next_rdata; // Next read data
  logic analog_loop; // Analog loopback bit
  logic digital_loop; // Digital loopback bit
  logic rx_tristate; // Receive port float bit
  logic full_duplex; // Filtered mode strap
  logic [2:0] mode_sync; // Strap synchroniser stages
  logic [2:0] next_mode_sync; // Next synchroniser stages
  logic next_full_duplex; // Next filtered strap
  logic [LBM_PORT_W-1:0] tx_s1; // Port sync stage 1
  logic [LBM_PORT_W-1:0] tx_s2; // Port sync stage 2
  logic [LBM_PORT_W-1:0] tx_s3; // Port sync stage 3
  logic [LBM_PORT_W-1:0] tx_port; // Agreed transmit port word
  logic [LBM_PORT_W-1:0] next_tx_port; // Next agreed word
  logic [LBM_PORT_W-1:0] rx_o; // Receive pin out register
  logic [LBM_PORT_W-1:0] next_rx_o; // Next receive pin value
  logic [LBM_PORT_W-1:0] rx_oe; // Receive enable register
  logic [LBM_PORT_W-1:0] next_rx_oe; // Next enables
  logic [LBM_ADC_W-1:0] buf_in_data; // Word offered to the buffer
  logic buf_in_valid; // Offer valid
  logic buf_in_ready; // Buffer has room
  logic [LBM_ADC_W-1:0] buf_out_data; // Buffer head word
  logic buf_out_valid; // Buffer head valid
  logic [LBM_ADC_W-1:0] interp_data; // Interpolator data register
  logic [LBM_ADC_W-1:0] next_interp_data; // Next interpolator data
  logic interp_valid; // Interpolator valid register
  logic next_interp_valid; // Next interpolator valid
  logic take; // Output stage loads a word
  logic buf_push; // Word enters the buffer on this edge
  logic room_after; // Buffer still has room after this edge
  logic adc_ready; // Sample acceptance register
  logic next_adc_ready; // Next acceptance
  logic loop_active; // Loopback status register
  logic next_loop_active; // Next loopback status

  assign analog_loop = test_ctrl[LBM_BIT_ANALOG_LOOP];
  assign digital_loop = test_ctrl[LBM_BIT_DIGITAL_LOOP];
  assign rx_tristate = test_ctrl[LBM_BIT_RX_TRISTATE];

  // Register write and read-back; unlisted addresses read as zero
  always_comb
  begin
    next_test_ctrl = test_ctrl;
    next_rdata = 8'h00;
    if (REG_WE && REG_ADDR == LBM_TEST_MODE_CONTROL_ADDR)
      next_test_ctrl = REG_WDATA;
    if (REG_ADDR == LBM_TEST_MODE_CONTROL_ADDR)
      next_rdata = test_ctrl;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      test_ctrl <= LBM_TEST_MODE_CONTROL_RESET;
      rdata <= 8'h00;
    end
    else
    begin
      test_ctrl <= next_test_ctrl;
      rdata <= next_rdata;
    end
  end

  // Strap and transmit pins come from outside: three stages, last two agree
  always_comb
  begin
    next_mode_sync = {mode_sync[1:0], MODE_PIN};
    next_full_duplex = full_duplex;
    if (mode_sync[1] == mode_sync[2])
      next_full_duplex = mode_sync[2];
    next_tx_port = tx_port;
    if (tx_s2 == tx_s3)
      next_tx_port = tx_s3;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      mode_sync <= 3'h0;
      full_duplex <= LBM_MODE_HALF;
      tx_s1 <= LBM_PORT_ZERO;
      tx_s2 <= LBM_PORT_ZERO;
      tx_s3 <= LBM_PORT_ZERO;
      tx_port <= LBM_PORT_ZERO;
    end
    else
    begin
      mode_sync <= next_mode_sync;
      full_duplex <= next_full_duplex;
      tx_s1 <= TX_PORT;
      tx_s2 <= tx_s1;
      tx_s3 <= tx_s2;
      tx_port <= next_tx_port;
    end
  end

  // Receive port routing; tristate has priority over any loopback data
  always_comb
  begin
    next_rx_o = RXP_DATA;
    next_rx_oe = {LBM_PORT_W{1'b1}};
    if (digital_loop && full_duplex == LBM_MODE_FULL)
      next_rx_o = tx_port;
    if (rx_tristate)
    begin
      next_rx_oe = LBM_PORT_ZERO;
      next_rx_o = LBM_PORT_ZERO;
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rx_o <= LBM_PORT_ZERO;
      rx_oe <= LBM_PORT_ZERO;
    end
    else
    begin
      rx_o <= next_rx_o;
      rx_oe <= next_rx_oe;
    end
  end

  // Transmit source select ahead of the interpolation filters
  always_comb
  begin
    buf_in_data = TXP_DATA;
    buf_in_valid = TXP_VALID;
    if (analog_loop)
    begin
      buf_in_data = ADC_DATA;
      buf_in_valid = ADC_VALID;
    end
  end

  // Two-entry buffer so an interpolator stall drops no ADC sample in analog loopback; host words offered while it is full are lost
  lbm_skid #(.W(LBM_ADC_W)) u_skid (
    .clk(CLK),
    .rst_b(RST_B),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(take),
    .out_data(buf_out_data)
  );

  // Registered output stage; loads when empty or being drained
  always_comb
  begin
    take = buf_out_valid && (!interp_valid || INTERP_READY);
    next_interp_data = interp_data;
    next_interp_valid = interp_valid;
    if (interp_valid && INTERP_READY)
      next_interp_valid = 1'b0;
    if (take)
    begin
      next_interp_data = buf_out_data;
      next_interp_valid = 1'b1;
    end
    // Registered ready must match the room the buffer has next cycle,
    // otherwise a sample offered against a stale high ready is dropped
    buf_push = buf_in_valid && buf_in_ready;
    // Full afterwards: full and not drained, or one held plus one more
    room_after = !((!buf_in_ready && !take) ||
      (buf_out_valid && buf_push && !take));
    // ADC ready reflects buffer room only while the ADC feeds transmit
    next_adc_ready = next_test_ctrl[LBM_BIT_ANALOG_LOOP] ? room_after : 1'b1;
    next_loop_active = analog_loop;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      interp_data <= LBM_ADC_ZERO;
      interp_valid <= 1'b0;
      adc_ready <= 1'b0;
      loop_active <= 1'b0;
    end
    else
    begin
      interp_data <= next_interp_data;
      interp_valid <= next_interp_valid;
      adc_ready <= next_adc_ready;
      loop_active <= next_loop_active;
    end
  end

  assign REG_RDATA = rdata;
  assign RX_PORT_O = rx_o;
  assign RX_PORT_OE = rx_oe;
  assign INTERP_DATA = interp_data;
  assign INTERP_VALID = interp_valid;
  assign ADC_READY = adc_ready;
  assign ANALOG_LOOP_ACTIVE = loop_active;
endmodule : lbm_loopback_test_mux

// ===== tb/lbm_checker.sv
// Port checker for the loopback test multiplexer.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module lbm_checker
  import lbm_pkg::*;
(
  input wire logic CLK, // Clock
  input wire logic RST_B, // Reset, active low
  input wire logic REG_WE, // Write strobe
  input wire logic [7:0] REG_ADDR, // Address
  input wire logic [7:0] REG_WDATA, // Write data
  input wire logic MODE_PIN, // Duplex strap
  input wire logic [5:0] TX_PORT, // Transmit pins
  input wire logic [5:0] RXP_DATA, // Normal receive word
  input wire logic [5:0] RX_PORT_O, // Receive pins
  input wire logic [5:0] RX_PORT_OE, // Receive enables
  input wire logic ANALOG_LOOP_ACTIVE, // Loop flag
  input wire logic INTERP_VALID, // Stream valid
  input wire logic INTERP_READY, // Stream ready
  input wire logic [11:0] INTERP_DATA // Stream word
);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic [2:0] mode; // Shadow of test bits 7:5
  logic [2:0] next_mode; // Shadow after this write
  // Follow writes so outputs can be tied to the register
  always_comb
  begin
    next_mode = mode;
    if (REG_WE && REG_ADDR == LBM_TEST_MODE_CONTROL_ADDR)
      next_mode = REG_WDATA[7:5];
  end
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      mode <= 3'h0;
    else
      mode <= next_mode;
  end
  property p_norm;
    mode == 3'h0 && $past(mode) == 3'h0 && $past(RST_B) |->
      RX_PORT_OE == 6'h3f && RX_PORT_O == $past(RXP_DATA);
  endproperty
  a_norm: assert property (p_norm)
    else $error("receive port not on normal word");
  property p_tri;
    mode[0] && $past(mode[0]) |-> RX_PORT_OE == 6'h00 && RX_PORT_O == 6'h00;
  endproperty
  a_tri: assert property (p_tri)
    else $error("receive port still driven");
  // word returned; settled pins need eight quiet cycles
  property p_dig;
    (mode == 3'h2 && MODE_PIN && $stable(TX_PORT))[*8] |->
      RX_PORT_O == TX_PORT;
  endproperty
  a_dig: assert property (p_dig)
    else $error("transmit word not returned");
  property p_ana;
    $stable(mode[2]) |-> ANALOG_LOOP_ACTIVE == mode[2];
  endproperty
  a_ana: assert property (p_ana)
    else $error("loop flag wrong");
  property p_hold;
    INTERP_VALID && !INTERP_READY |=> INTERP_VALID && $stable(INTERP_DATA);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled word lost");
endmodule : lbm_checker
bind lbm_loopback_test_mux lbm_checker u_chk (.CLK, .RST_B, .REG_WE,
  .REG_ADDR, .REG_WDATA, .MODE_PIN, .TX_PORT, .RXP_DATA, .RX_PORT_O,
  .RX_PORT_OE, .ANALOG_LOOP_ACTIVE, .INTERP_VALID, .INTERP_READY,
  .INTERP_DATA);

// ===== tb/lbm_partner.sv
// Back-end model: drives transmit pins, sinks the filter stream.
// Assumes the bench sets stall and the pin word at clock edges.
`timescale 1ns/1ps
module lbm_partner
(
  input wire logic clk, // Clock
  input wire logic stall, // Hold off the stream
  input wire logic [5:0] tx_word, // Word for transmit pins
  output logic [5:0] tx_pins, // Transmit pins
  output logic ready, // Stream ready
  input wire logic valid, // Stream valid
  input wire logic [11:0] data, // Stream word
  input wire logic [5:0] rx_o, // Receive pin drive
  input wire logic [5:0] rx_oe, // Receive pin enables
  output logic [5:0] rx_wire // Level on the pins
);
  logic [11:0] got[$]; // Words taken
  logic [5:0] last = 6'h00; // Last pin level
  assign tx_pins = tx_word;
  assign ready = !stall;
  // Floated pins toggle, so a held stale value cannot pass
  assign rx_wire = (rx_oe & rx_o) | (~rx_oe & ~last);
  always @(posedge clk)
  begin
    last <= rx_wire;
    if (valid && ready)
      got.push_back(data);
  end
endmodule : lbm_partner

// ===== tb/lbm_loopback_test_mux_tb.sv
// Bench for the loopback test multiplexer with a back-end model.
// Assumes registered outputs settle within one clock.
`timescale 1ns/1ps
module lbm_loopback_test_mux_tb;
  logic CLK = 1'b0, RST_B = 1'b0, REG_WE = 1'b0, MODE_PIN = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
  logic [11:0] ADC_DATA = 12'h000, TXP_DATA = 12'h000, INTERP_DATA;
  logic ADC_VALID = 1'b0, TXP_VALID = 1'b0, ADC_READY, INTERP_VALID;
  logic INTERP_READY, ANALOG_LOOP_ACTIVE, stall = 1'b0, low;
  logic [5:0] TX_PORT, RX_PORT_O, RX_PORT_OE, rx_wire;
  logic [5:0] RXP_DATA = 6'h00, tx_word = 6'h00;
  int fail_count = 0, n_tests = 0;
  lbm_loopback_test_mux u_dut (.CLK, .RST_B, .REG_WE, .REG_ADDR,
    .REG_WDATA, .REG_RDATA, .MODE_PIN, .ADC_DATA, .ADC_VALID, .ADC_READY,
    .TXP_DATA, .TXP_VALID, .INTERP_DATA, .INTERP_VALID, .INTERP_READY,
    .TX_PORT, .RX_PORT_O, .RX_PORT_OE, .RXP_DATA, .ANALOG_LOOP_ACTIVE);
  lbm_partner u_bk (.clk(CLK), .stall, .tx_word, .tx_pins(TX_PORT),
    .ready(INTERP_READY), .valid(INTERP_VALID), .data(INTERP_DATA),
    .rx_o(RX_PORT_O), .rx_oe(RX_PORT_OE), .rx_wire);
  initial
  begin
    forever #5 CLK = ~CLK;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_WE <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WE <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK);
    REG_ADDR <= a;
    repeat (2) @(posedge CLK);
    #1 chk(REG_RDATA, e);
  endtask : rd
  task automatic pop(input logic [11:0] e);
    chk(u_bk.got.size() > 0 ? u_bk.got.pop_front() : 12'hxxx, e);
  endtask : pop
  // Offer one sample, bounded wait for acceptance
  // Ready is read settled, just after an edge, for the edge that follows
  task automatic send(input logic [11:0] w);
    int i;
    logic seen;
    ADC_DATA <= w;
    ADC_VALID <= 1'b1;
    i = 0;
    seen = 1'b0;
    do
    begin
      #1 seen = ADC_READY;
      @(posedge CLK);
      i++;
      if (!seen)
        low = 1'b1;
    end while (!seen && i < 60);
    if (!seen)
    begin
      fail_count++;
      end_of_test();
    end
  endtask : send
  task automatic t_reg;
    rd(8'h0d, 8'h00);
    wr(8'h0d, 8'h1f);
    rd(8'h0d, 8'h1f);
    wr(8'h0e, 8'hff);
    rd(8'h0e, 8'h00);
    rd(8'h0d, 8'h1f);
  endtask : t_reg
  task automatic t_norm;
    @(posedge CLK);
    RXP_DATA <= 6'h2a;
    TXP_DATA <= 12'h5a5;
    TXP_VALID <= 1'b1;
    @(posedge CLK);
    TXP_VALID <= 1'b0;
    repeat (5) @(posedge CLK);
    #1 chk(rx_wire, 6'h2a);
    pop(12'h5a5);
  endtask : t_norm
  task automatic t_tri;
    for (int m = 0; m < 2; m++)
    begin
      @(posedge CLK);
      MODE_PIN <= m[0];
      wr(8'h0d, 8'h20);
      repeat (6) @(posedge CLK);
      #1 chk(RX_PORT_OE, 6'h00);
    end
  endtask : t_tri
  task automatic t_dig;
    @(posedge CLK);
    MODE_PIN <= 1'b1;
    tx_word <= 6'h15;
    wr(8'h0d, 8'h40);
    repeat (10) @(posedge CLK);
    #1 chk(rx_wire, 6'h15);
    @(posedge CLK);
    tx_word <= 6'h2c;
    repeat (8) @(posedge CLK);
    #1 chk(rx_wire, 6'h2c);
    @(posedge CLK);
    MODE_PIN <= 1'b0;
    repeat (10) @(posedge CLK);
    #1 chk(rx_wire, 6'h2a);
  endtask : t_dig
  // Samples kept near quarter scale, clear of clipping
  task automatic t_ana;
    for (int m = 0; m < 2; m++)
    begin
      @(posedge CLK);
      MODE_PIN <= m[0];
      wr(8'h0d, 8'h80);
      stall <= 1'b1;
      low = 1'b0;
      fork
      begin
        repeat (20) @(posedge CLK);
        stall <= 1'b0;
      end
      join_none
      for (int k = 0; k < 6; k++)
        send(12'h3c0 + 12'(k));
      ADC_VALID <= 1'b0;
      for (int i = 0; i < 60 && u_bk.got.size() < 6; i++)
        @(posedge CLK);
      #1 chk(ANALOG_LOOP_ACTIVE, 1'b1);
      chk(low, 1'b1);
      for (int k = 0; k < 6; k++)
        pop(12'h3c0 + 12'(k));
    end
  endtask : t_ana
  initial
  begin
    repeat (16) @(posedge CLK);
    RST_B <= 1'b1;
    t_reg();
    t_norm();
    t_tri();
    t_dig();
    t_ana();
    end_of_test();
  end
endmodule : lbm_loopback_test_mux_tb
